// ===== logic/sfi_pkg.sv
// Constants and carrier types for the serial frame interface
package sfi_pkg;
    // ==================================================================
    // Frame geometry
    localparam int FRAME_BITS = 16;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] CNT_IDLE = 5'h00;
    localparam logic [CNT_W-1:0] CNT_LAST = 5'(FRAME_BITS - 1);
    localparam logic [CNT_W-1:0] CNT_FULL = 5'(FRAME_BITS);
    localparam logic [FRAME_BITS-1:0] WORD_RESET = 16'h0000;
    localparam int MSB = FRAME_BITS - 1;

    // ==================================================================
    // Port pins
    localparam int NUM_PINS = 8;
    localparam int BUSY_PIN = NUM_PINS - 1;
    localparam logic [NUM_PINS-1:0] PINS_RESET = 8'h00;
    localparam logic [1:0] MODE_DAC = 2'h0;
    localparam logic [1:0] MODE_ADC = 2'h1;
    localparam logic [1:0] MODE_GPI = 2'h2;
    localparam logic [1:0] MODE_GPO = 2'h3;

    // ==================================================================
    // Output word sources
    localparam logic [1:0] SRC_ADC = 2'h0;
    localparam logic [1:0] SRC_READBACK = 2'h1;
    localparam logic [1:0] SRC_TEMP = 2'h2;

    typedef struct packed {
        logic [1:0] src;
        logic [FRAME_BITS-1:0] adc_result;
        logic [FRAME_BITS-1:0] readback;
        logic [FRAME_BITS-1:0] temperature;
    } tx_src_s;

    typedef struct packed {
        logic [NUM_PINS-1:0][1:0] mode;
        logic [NUM_PINS-1:0] gpo_level;
        logic busy_on;
    } pin_cfg_s;

    typedef struct packed {
        logic valid;
        logic [FRAME_BITS-1:0] word;
    } rx_frame_s;
endpackage : sfi_pkg

// ===== logic/serial_frame_interface.sv
// Serial target: framed input shifter, output shifter and port pin muxing
//
// Contract
// - Input bits sampled on falling serial clock
// - Frame is next sixteen falling edges
// - Output MSB appears at frame select fall
// - Later bits shift on rise after fall
// - Output carries results, readback, temperature
// - Frame select low marks frame boundary
// - Pin function follows pin configuration
// - Highest pin may show conversion busy
// - Async reset restores default configuration
`timescale 1ns/10ps
`default_nettype none
module serial_frame_interface (
    input wire logic mclk, // 200 MHz system clock
    input wire logic resetn, // Async reset, active low
    input wire logic frame_sel_n, // Frame select pin, active low
    input wire logic sclk, // Serial clock pin
    input wire logic serial_in, // Serial data pin
    output logic serial_out, // Serial data out pin
    input wire sfi_pkg::tx_src_s tx_src, // Words offered for output
    output sfi_pkg::rx_frame_s rx_frame, // Received word, valid pulse
    input wire sfi_pkg::pin_cfg_s pin_cfg, // Pin configuration
    input wire logic conv_busy, // Conversion in progress
    input wire logic [7:0] pin_in, // Port pin input levels
    output logic [7:0] pin_out, // Port pin output levels
    output logic [7:0] pin_oe, // Port pin output enables
    output logic [7:0] dac_sel, // Pin routed to a converter output
    output logic [7:0] adc_sel, // Pin routed to the converter input
    output logic [7:0] gpio_in // Synchronised digital input levels
);
    import sfi_pkg::*;

    // ==================================================================
    // Pin synchronisers
    logic sclk_m, sclk_s, sclk_d;
    logic fs_m, fs_s, fs_d;
    logic sin_m, sin_s;
    logic [NUM_PINS-1:0] pin_m, pin_s;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sclk_m <= 1'b0;
            sclk_s <= 1'b0;
            sclk_d <= 1'b0;
            fs_m <= 1'b1;
            fs_s <= 1'b1;
            fs_d <= 1'b1;
            sin_m <= 1'b0;
            sin_s <= 1'b0;
            pin_m <= PINS_RESET;
            pin_s <= PINS_RESET;
        end else begin
            sclk_m <= sclk;
            sclk_s <= sclk_m;
            sclk_d <= sclk_s;
            fs_m <= frame_sel_n;
            fs_s <= fs_m;
            fs_d <= fs_s;
            sin_m <= serial_in;
            sin_s <= sin_m;
            pin_m <= pin_in;
            pin_s <= pin_m;
        end
    end

    logic sclk_fall, sclk_rise, frame_start, frame_act;
    assign sclk_fall = sclk_d & ~sclk_s;
    assign sclk_rise = ~sclk_d & sclk_s;
    assign frame_start = fs_d & ~fs_s;
    assign frame_act = ~fs_s;

    // ==================================================================
    // Input shifter
    logic [CNT_W-1:0] bit_cnt_r;
    logic [FRAME_BITS-1:0] rx_shift_r;
    logic [FRAME_BITS-1:0] rx_word_r;
    logic rx_valid_r;

    // Edges past the sixteenth are dropped, not wrapped into a new word
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            bit_cnt_r <= CNT_IDLE;
            rx_shift_r <= WORD_RESET;
        end else if (!frame_act) begin
            bit_cnt_r <= CNT_IDLE;
        end else if (sclk_fall && bit_cnt_r != CNT_FULL) begin
            bit_cnt_r <= bit_cnt_r + 5'h01;
            rx_shift_r <= {rx_shift_r[MSB-1:0], sin_s};
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rx_word_r <= WORD_RESET;
            rx_valid_r <= 1'b0;
        end else begin
            rx_valid_r <= 1'b0;
            if (frame_act && sclk_fall && bit_cnt_r == CNT_LAST) begin
                rx_word_r <= {rx_shift_r[MSB-1:0], sin_s};
                rx_valid_r <= 1'b1;
            end
        end
    end

    assign rx_frame.valid = rx_valid_r;
    assign rx_frame.word = rx_word_r;

    // ==================================================================
    // Output shifter
    function automatic logic [FRAME_BITS-1:0] pick_word(input tx_src_s s);
        case (s.src)
            SRC_ADC: pick_word = s.adc_result;
            SRC_READBACK: pick_word = s.readback;
            SRC_TEMP: pick_word = s.temperature;
            default: pick_word = WORD_RESET;
        endcase
    endfunction : pick_word

    logic [FRAME_BITS-1:0] tx_shift_r;
    logic armed_r;

    // Armed by a fall, so the first rise after an idle-low clock is skipped
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tx_shift_r <= WORD_RESET;
            armed_r <= 1'b0;
        end else if (frame_start) begin
            tx_shift_r <= pick_word(tx_src);
            armed_r <= 1'b0;
        end else if (!frame_act) begin
            armed_r <= 1'b0;
        end else if (sclk_fall) begin
            armed_r <= 1'b1;
        end else if (sclk_rise && armed_r) begin
            tx_shift_r <= {tx_shift_r[MSB-1:0], 1'b0};
            armed_r <= 1'b0;
        end
    end

    assign serial_out = tx_shift_r[MSB];

    // ==================================================================
    // Port pin function
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pin_out <= PINS_RESET;
            pin_oe <= PINS_RESET;
            dac_sel <= PINS_RESET;
            adc_sel <= PINS_RESET;
            gpio_in <= PINS_RESET;
        end else begin
            for (int i = 0; i < NUM_PINS; i++) begin
                dac_sel[i] <= pin_cfg.mode[i] == MODE_DAC;
                adc_sel[i] <= pin_cfg.mode[i] == MODE_ADC;
                pin_oe[i] <= pin_cfg.mode[i] == MODE_GPO;
                pin_out[i] <= (pin_cfg.mode[i] == MODE_GPO) & pin_cfg.gpo_level[i];
                gpio_in[i] <= (pin_cfg.mode[i] == MODE_GPI) & pin_s[i];
            end
            if (pin_cfg.busy_on) begin
                pin_oe[BUSY_PIN] <= 1'b1;
                pin_out[BUSY_PIN] <= conv_busy;
            end
        end
    end

    // ==================================================================
    // Checks
    sequence seq_fall_in_frame;
        frame_act && sclk_fall && !frame_start;
    endsequence

    sequence seq_rise_armed;
        frame_act && sclk_rise && armed_r && !frame_start;
    endsequence

    a_msb_at_start: assert property (@(posedge mclk) disable iff (!resetn)
        frame_start |=> serial_out == $past(pick_word(tx_src)) >> MSB)
        else $error("output msb not loaded at frame start");

    a_idle_clear: assert property (@(posedge mclk) disable iff (!resetn)
        !frame_act |=> bit_cnt_r == CNT_IDLE && !armed_r)
        else $error("input state not idle outside frame");

    a_count_step: assert property (@(posedge mclk) disable iff (!resetn)
        seq_fall_in_frame ##0 (bit_cnt_r != CNT_FULL) |=> bit_cnt_r == $past(bit_cnt_r) + 5'h01)
        else $error("bit count did not advance on falling edge");

    a_count_cap: assert property (@(posedge mclk) disable iff (!resetn)
        bit_cnt_r <= CNT_FULL)
        else $error("bit count beyond frame length");

    a_word_done: assert property (@(posedge mclk) disable iff (!resetn)
        rx_valid_r |-> bit_cnt_r == CNT_FULL ##1 !rx_valid_r)
        else $error("word valid not tied to sixteenth edge");

    a_sample_bit: assert property (@(posedge mclk) disable iff (!resetn)
        seq_fall_in_frame ##0 (bit_cnt_r == CNT_LAST) |=> rx_word_r[0] == $past(sin_s))
        else $error("last bit not sampled on falling edge");

    a_shift_rise: assert property (@(posedge mclk) disable iff (!resetn)
        seq_rise_armed |=> serial_out == $past(tx_shift_r[MSB-1]) && !armed_r)
        else $error("output did not advance on rise after fall");

    a_hold_unarmed: assert property (@(posedge mclk) disable iff (!resetn)
        frame_act && !frame_start && sclk_rise && !armed_r |=> $stable(serial_out))
        else $error("output moved on rise without prior fall");

    a_tx_idle: assert property (@(posedge mclk) disable iff (!resetn)
        !frame_act |=> $stable(serial_out))
        else $error("output moved while frame select high");

    a_busy_pin: assert property (@(posedge mclk) disable iff (!resetn)
        pin_cfg.busy_on |=> pin_oe[BUSY_PIN] && pin_out[BUSY_PIN] == $past(conv_busy))
        else $error("busy pin does not follow conversion");

    a_pin_route: assert property (@(posedge mclk) disable iff (!resetn)
        pin_cfg.mode[0] == MODE_ADC |=> adc_sel[0] && !dac_sel[0] && !pin_oe[0])
        else $error("pin routing does not follow configuration");
endmodule : serial_frame_interface
`default_nettype wire

// ===== verif/sfi_host.sv
// Serial host model: frames, serial clock and data toward the device
`timescale 1ns/10ps
`default_nettype none
module sfi_host (
    input wire logic mclk, // Bench clock, paces the link
    output logic frame_sel_n, // Frame select, active low
    output logic sclk, // Serial clock, idle level from idle_hi
    output logic serial_in, // Data to the device
    input wire logic serial_out // Data from the device
);
    // 160 ns link period is 32 bench clocks
    localparam int HALF = 16;
    localparam int QUART = 8;
    logic idle_hi = 1'b0;
    initial begin
        frame_sel_n = 1'b1;
        sclk = 1'b0;
        serial_in = 1'b0;
    end
    // 160 ns period stays below both host clock limits
    task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
        rx = 16'h0000;
        @(posedge mclk);
        frame_sel_n <= 1'b0;
        // Each bit is read just before the falling edge, in both idle levels
        for (int i = 15; i > 15 - nbits; i--) begin
            serial_in <= tx[i];
            repeat (QUART) @(posedge mclk);
            if (idle_hi) rx[i] = serial_out;
            sclk <= ~sclk;
            repeat (HALF) @(posedge mclk);
            if (!idle_hi) rx[i] = serial_out;
            sclk <= ~sclk;
            repeat (QUART) @(posedge mclk);
        end
        repeat (HALF) @(posedge mclk);
        frame_sel_n <= 1'b1;
        // Released line must not keep the last bit
        serial_in <= ~serial_in;
        repeat (HALF) @(posedge mclk);
    endtask : xfer
    task automatic set_idle(input logic hi);
        idle_hi = hi;
        @(posedge mclk);
        sclk <= hi;
        repeat (HALF) @(posedge mclk);
    endtask : set_idle
    task automatic idle_clocks(input int n);
        repeat (2 * n) begin
            repeat (HALF) @(posedge mclk);
            sclk <= ~sclk;
        end
    endtask : idle_clocks
endmodule : sfi_host
`default_nettype wire

// ===== verif/tb_top.sv
// Testbench: frames through the host model, pin muxing and reset
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import sfi_pkg::*;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic frame_sel_n, sclk, serial_in, serial_out, conv_busy = 1'b0;
    tx_src_s tx_src = '0;
    rx_frame_s rx_frame;
    pin_cfg_s pin_cfg = '0;
    logic [7:0] pin_in = 8'h00, pin_out, pin_oe, dac_sel, adc_sel, gpio_in;
    int errors = 0, compares = 0, nvalid = 0;
    always #2.5 mclk = ~mclk;
    always @(posedge mclk) begin
        if (rx_frame.valid === 1'b1) nvalid <= nvalid + 1;
    end
    serial_frame_interface i_dut (.mclk(mclk), .resetn(resetn), .frame_sel_n(frame_sel_n),
        .sclk(sclk), .serial_in(serial_in), .serial_out(serial_out), .tx_src(tx_src),
        .rx_frame(rx_frame), .pin_cfg(pin_cfg), .conv_busy(conv_busy), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .dac_sel(dac_sel), .adc_sel(adc_sel),
        .gpio_in(gpio_in));
    sfi_host i_host (.mclk(mclk), .frame_sel_n(frame_sel_n), .sclk(sclk),
        .serial_in(serial_in), .serial_out(serial_out));
    // ==========================================
    // Checking and verdict
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check
    task automatic final_report;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : final_report
    // ==========================================
    // Scenarios
    task automatic t_frames;
        logic [15:0] words [4] = '{16'h8001, 16'h5A3C, 16'hFFFE, 16'hC3A5};
        logic [15:0] expw [4] = '{16'hA5C3, 16'h3C5A, 16'h8421, 16'h0000};
        logic [15:0] rx;
        int n;
        tx_src.adc_result <= 16'hA5C3;
        tx_src.readback <= 16'h3C5A;
        tx_src.temperature <= 16'h8421;
        // Second pass parks the link clock high between frames
        for (int s = 0; s < 8; s++) begin
            if (s == 4) i_host.set_idle(1'b1);
            @(posedge mclk);
            tx_src.src <= 2'(s % 4);
            n = nvalid;
            @(posedge mclk);
            i_host.xfer(words[s % 4], 16, rx);
            check(rx, expw[s % 4], "output word");
            check(rx_frame.word, words[s % 4], "input word");
            check(16'(nvalid - n), 16'h0001, "valid pulses");
        end
        i_host.set_idle(1'b0);
        $display("t_frames done");
    endtask : t_frames
    task automatic t_abort;
        logic [15:0] rx;
        int n;
        n = nvalid;
        i_host.xfer(16'h1234, 9, rx);
        i_host.idle_clocks(20);
        check(rx_frame.word, 16'hC3A5, "word after abort");
        check(16'(nvalid - n), 16'h0000, "no valid");
        tx_src.src <= 2'h1;
        i_host.xfer(16'h0F0F, 16, rx);
        check(rx_frame.word, 16'h0F0F, "word after idle");
        check(rx, 16'h3C5A, "output after idle");
        $display("t_abort done");
    endtask : t_abort
    task automatic t_pins;
        logic [7:0] m0, m1, m2, m3;
        for (int k = 0; k < 4; k++) begin
            @(posedge mclk);
            for (int i = 0; i < 8; i++) begin
                pin_cfg.mode[i] <= 2'((i + k) % 4);
                {m3[i], m2[i], m1[i], m0[i]} = 4'b0001 << ((i + k) % 4);
            end
            pin_cfg.gpo_level <= 8'hA5;
            pin_in <= 8'h3C;
            repeat (5) @(posedge mclk);
            check(16'(dac_sel), 16'(m0), "dac select");
            check(16'(adc_sel), 16'(m1), "adc select");
            check(16'(gpio_in), 16'(m2 & 8'h3C), "digital in");
            check(16'(pin_oe), 16'(m3), "output enable");
            check(16'(pin_out & m3), 16'(m3 & 8'hA5), "output level");
        end
        pin_cfg.busy_on <= 1'b1;
        for (int b = 0; b < 2; b++) begin
            conv_busy <= b[0];
            repeat (3) @(posedge mclk);
            check(16'({pin_oe[7], pin_out[7]}), 16'({1'b1, b[0]}), "busy pin");
        end
        pin_cfg.busy_on <= 1'b0;
        $display("t_pins done");
    endtask : t_pins
    task automatic t_reset;
        logic [15:0] rx;
        pin_cfg.mode <= '1;
        pin_cfg.gpo_level <= 8'hFF;
        tx_src.src <= 2'h2;
        fork
            i_host.xfer(16'hFFFF, 16, rx);
            begin
                repeat (300) @(posedge mclk);
                resetn <= 1'b0;
                #1 check(16'({pin_oe, serial_out, rx_frame.valid}), 16'h0000, "reset");
            end
        join
        @(posedge mclk);
        resetn <= 1'b1;
        repeat (4) @(posedge mclk);
        i_host.xfer(16'h6C93, 16, rx);
        check(rx_frame.word, 16'h6C93, "word after reset");
        $display("t_reset done");
    endtask : t_reset
    initial begin
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        repeat (4) @(posedge mclk);
        t_frames;
        t_abort;
        t_pins;
        t_reset;
        final_report;
    end
    // Whole run needs about 35 us
    initial begin
        #100us;
        errors++;
        final_report;
    end
endmodule : tb_top
`default_nettype wire
